// ---- lmw_ctrl.sv ----
// LIN transceiver mode, wake and fault control
`timescale 1ns/100ps
module lmw_ctrl
#(
   parameter int         WAKE_CYC  = lmw_pkg::WAKE_CYC_DEF,
   parameter int         TO_CYC    = lmw_pkg::TO_CYC_DEF,
   parameter logic [1:0] MODE_OFF  = lmw_pkg::MODE_OFF_DEF,
   parameter logic [1:0] MODE_RX   = lmw_pkg::MODE_RX_DEF,
   parameter logic [1:0] MODE_NRM  = lmw_pkg::MODE_NRM_DEF
)
(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // Pins and analog front end
   input  wire logic                 lin_transmit_input,
   input  wire logic                 bus_rx_level,
   input  wire logic                 supply_uv,
   input  wire logic                 spi_select_low,
   output logic                      lin_receive_output,
   output logic                      bus_drive_dominant,
   // Chip mode and configuration
   input  wire lmw_pkg::lmw_sbc_type sbc_mode,
   input  wire lmw_pkg::lmw_cfg_type cfg,
   // Status and requests
   output lmw_pkg::lmw_stat_type     stat,
   output lmw_pkg::lmw_req_type      req,
   output logic                      int_n,
   // Event stream
   output logic                      evt_valid,
   input  wire logic                 evt_ready,
   output lmw_pkg::lmw_evt_type      evt_data
);
   import lmw_pkg::*;

   logic [3:0]       sync1_r;
   logic [3:0]       sync2_r;
   logic             txd_s;
   logic             bus_s;
   logic             uv_s;
   logic             cs_s;
   logic             cs_prev_r;
   lmw_sbc_type      sbc_prev_r;
   lmw_st_type       st_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] txd_cnt_r;
   logic [CNT_W-1:0] bus_cnt_r;
   logic [1:0]       mode_r;
   logic             tx_arm_r;
   logic             txd_block_r;
   logic             bus_drive_r;
   logic             driver_en_r;
   logic             rx_r;
   logic             fault_r;
   logic             txd_stat_r;
   logic             clamp_stat_r;
   logic             wake_stat_r;
   logic             slope_pend_r;
   logic             low_slope_r;
   logic             int_n_r;
   lmw_req_type      req_r;
   logic [2:0]       evt_pend_r;
   logic             push_ready;
   logic             mode_chg;
   logic             rearm;
   logic             wake_evt;
   logic             txd_to_evt;
   logic             clamp_evt;
   logic             line_on;

   function automatic logic mode_ok(input logic [1:0] m,
                                    input lmw_sbc_type s);
      if (m == MODE_NRM)
         mode_ok = (s == SBC_NORMAL);
      else if (m == MODE_RX)
         mode_ok = (s == SBC_NORMAL) || (s == SBC_STOP);
      else
         mode_ok = (s != SBC_FAILSAFE);
   endfunction

   function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] c);
      inc = (&c) ? c : c + 1'b1;
   endfunction

   function automatic lmw_st_type entry(input logic [1:0] m);
      if (m == MODE_NRM)
         entry = ST_EN_WAIT;
      else if (m == MODE_RX)
         entry = ST_RXONLY;
      else if (m == MODE_WAKE)
         entry = ST_WK_IDLE;
      else
         entry = ST_OFF;
   endfunction

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r   <= SYNC_RST;
         sync2_r   <= SYNC_RST;
         cs_prev_r <= 1'b1;
      end
      else
      begin
         sync1_r   <= {spi_select_low, supply_uv, bus_rx_level,
                       lin_transmit_input};
         sync2_r   <= sync1_r;
         cs_prev_r <= cs_s;
      end
   end

   assign txd_s = sync2_r[0];
   assign bus_s = sync2_r[1];
   assign uv_s  = sync2_r[2];
   assign cs_s  = sync2_r[3];

   assign mode_chg = cfg.mode_wr && mode_ok(cfg.mode_req, sbc_mode)
                     && (cfg.mode_req != mode_r); // R3 R21
   assign rearm = ((sbc_mode != sbc_prev_r) &&
                   (sbc_mode == SBC_STOP || sbc_mode == SBC_SLEEP ||
                    sbc_mode == SBC_FAILSAFE))
                  || (sbc_mode == SBC_STOP && cfg.stop_cmd); // R10
   assign wake_evt = (st_r == ST_WK_QUAL) && bus_s && !mode_chg
                     && !rearm; // R5
   assign line_on = (st_r == ST_NORMAL) || (st_r == ST_EN_WAIT)
                    || (st_r == ST_RXONLY);
   assign txd_to_evt = (st_r == ST_NORMAL) && !txd_s && !txd_block_r
                       && !cfg.transmit_timeout_disable
                       && (txd_cnt_r == CNT_W'(TO_CYC - 1)); // R14 R15
   assign clamp_evt = line_on && !bus_s
                      && (bus_cnt_r == CNT_W'(TO_CYC - 1)); // R16

   // Mode field
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r     <= MODE_OFF; // R20
         sbc_prev_r <= SBC_NORMAL;
      end
      else
      begin
         sbc_prev_r <= sbc_mode;
         if (sbc_mode == SBC_FAILSAFE)
            mode_r <= MODE_WAKE; // R4
         else if (mode_chg)
            mode_r <= cfg.mode_req; // R23
      end
   end

   // Transceiver state and shared timer
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r  <= ST_OFF;
         cnt_r <= '0;
      end
      else if (mode_chg)
      begin
         st_r  <= entry(cfg.mode_req); // R9
         cnt_r <= '0;
      end
      else if ((sbc_mode == SBC_FAILSAFE && mode_r != MODE_WAKE)
               || (rearm && mode_r == MODE_WAKE))
      begin
         st_r  <= ST_WK_IDLE; // R4 R10
         cnt_r <= '0;
      end
      else
      begin
         case (st_r)
            ST_EN_WAIT:
            begin
               cnt_r <= inc(cnt_r);
               if (cnt_r == CNT_W'(EN_CYC - 1))
                  st_r <= ST_NORMAL; // R1 R24
            end
            ST_WK_IDLE:
            begin
               cnt_r <= '0;
               if (!bus_s)
                  st_r <= ST_WK_DOM;
            end
            ST_WK_DOM:
            begin
               cnt_r <= inc(cnt_r);
               if (bus_s)
                  st_r <= ST_WK_IDLE;
               else if (cnt_r == CNT_W'(WAKE_CYC - 1))
                  st_r <= ST_WK_QUAL; // R22 R24
            end
            ST_WK_QUAL:
            begin
               if (bus_s)
                  st_r <= ST_WOKEN; // R5 R8
            end
            default:
               st_r <= st_r; // R20
         endcase
      end
   end

   // Transmit path gating
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_arm_r    <= 1'b0;
         txd_cnt_r   <= '0;
         txd_block_r <= 1'b0;
         bus_drive_r <= 1'b0;
         driver_en_r <= 1'b0;
      end
      else
      begin
         tx_arm_r <= (st_r == ST_NORMAL) && (tx_arm_r || txd_s); // R2
         txd_cnt_r <= (txd_s || st_r != ST_NORMAL) ? '0 : inc(txd_cnt_r);
         if (txd_s)
            txd_block_r <= 1'b0; // R14
         else if (txd_to_evt)
            txd_block_r <= 1'b1; // R14
         driver_en_r <= (st_r == ST_NORMAL) && !uv_s
                        && !txd_block_r; // R3 R17
         bus_drive_r <= (st_r == ST_NORMAL) && tx_arm_r && !txd_s
                        && !txd_block_r && !uv_s; // R1 R2 R14 R17
      end
   end

   // Receive output and bus clamp timer
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_r      <= 1'b1;
         bus_cnt_r <= '0;
      end
      else
      begin
         if (st_r == ST_WOKEN)
            rx_r <= 1'b0; // R6 R13
         else
            rx_r <= line_on ? bus_s : 1'b1; // R3
         bus_cnt_r <= (bus_s || !line_on) ? '0 : inc(bus_cnt_r);
      end
   end

   // Sticky status, set wins over clear
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_r      <= 1'b0;
         txd_stat_r   <= 1'b0;
         clamp_stat_r <= 1'b0;
         wake_stat_r  <= 1'b0;
      end
      else
      begin
         fault_r      <= txd_to_evt || clamp_evt
                         || (fault_r && !cfg.fault_clr); // R14 R16
         txd_stat_r   <= txd_to_evt || (txd_stat_r && !cfg.fault_clr);
         clamp_stat_r <= clamp_evt || (clamp_stat_r && !cfg.fault_clr);
         wake_stat_r  <= wake_evt
                         || (wake_stat_r && !cfg.wake_clr); // R11
      end
   end

   // Wake actions by chip mode
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_n_r <= 1'b1;
         req_r   <= '0;
      end
      else
      begin
         int_n_r <= !(wake_evt && (sbc_mode == SBC_NORMAL ||
                                   sbc_mode == SBC_STOP)); // R7 R11
         req_r.restart_req <= wake_evt && (sbc_mode == SBC_SLEEP ||
                              sbc_mode == SBC_FAILSAFE); // R7 R13
         req_r.supply_ramp_req <= wake_evt && (sbc_mode == SBC_SLEEP ||
                                  sbc_mode == SBC_FAILSAFE); // R7
         req_r.wd_enable_req <= wake_evt && sbc_mode == SBC_STOP
                                && cfg.wd_disabled
                                && cfg.watchdog_on_bus_wake_enable; // R12
      end
   end

   // Slope selection
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slope_pend_r <= 1'b0;
         low_slope_r  <= 1'b0; // R18
      end
      else
      begin
         if (cfg.slope_wr && sbc_mode == SBC_NORMAL)
            slope_pend_r <= cfg.low_slope_select; // R19
         if (cs_s && !cs_prev_r)
            low_slope_r <= slope_pend_r; // R19
      end
   end

   // Pending events held while the FIFO is full
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         evt_pend_r <= 3'h0;
      else
         evt_pend_r <= ((|evt_pend_r && push_ready) ? 3'h0 : evt_pend_r)
                       | {clamp_evt, txd_to_evt, wake_evt};
   end

   lmw_fifo
   #(
      .W     ($bits(lmw_evt_type)),
      .DEPTH (FIFO_DEPTH),
      .AW    (4)
   )
   u_fifo
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (|evt_pend_r),
      .in_ready  (push_ready),
      .in_data   ({sbc_prev_r, evt_pend_r}),
      .out_valid (evt_valid),
      .out_ready (evt_ready),
      .out_data  (evt_data)
   );

   assign lin_receive_output = rx_r;
   assign bus_drive_dominant = bus_drive_r;
   assign int_n = int_n_r;
   assign req = req_r;
   assign stat = '{transceiver_a_mode_field: mode_r,
                   transceiver_a_fault_flag: fault_r,
                   txd_timeout_stat:         txd_stat_r,
                   bus_clamp_stat:           clamp_stat_r,
                   wake_source_status_reg:   wake_stat_r,
                   low_slope_active:         low_slope_r,
                   driver_enable:            driver_en_r};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   chk_en_wait_drive: assert property ( // R1
      st_r == ST_EN_WAIT |=> !bus_drive_r)
      else $error("dominant driven during enabling");
   chk_arm_gate: assert property ( // R2
      $rose(st_r == ST_NORMAL) && !txd_s ##1 !txd_s |=> !bus_drive_r)
      else $error("held dominant passed after enabling");
   chk_rxonly_drv: assert property ( // R3
      st_r == ST_RXONLY |=> !bus_drive_r && !driver_en_r)
      else $error("driver active in receive-only");
   chk_fs_mode: assert property ( // R4
      sbc_mode == SBC_FAILSAFE |=> mode_r == MODE_WAKE)
      else $error("fail-safe did not force wake-capable");
   chk_wake_rx: assert property ( // R6
      wake_evt |-> ##2 !lin_receive_output)
      else $error("receive output not low after wake");
   chk_woken_mode: assert property ( // R8
      st_r == ST_WOKEN |-> mode_r == MODE_WAKE)
      else $error("mode field left wake-capable");
   chk_int_stop: assert property ( // R7
      wake_evt && (sbc_mode == SBC_NORMAL || sbc_mode == SBC_STOP)
      |=> !int_n ##1 int_n)
      else $error("interrupt pulse missing");
   chk_sleep_noint: assert property ( // R13
      wake_evt && sbc_mode == SBC_SLEEP |=> int_n && req.restart_req)
      else $error("sleep wake handled wrongly");
   chk_txd_block: assert property ( // R14
      txd_to_evt |=> txd_block_r && fault_r ##1 !bus_drive_r)
      else $error("timeout did not block driver");
   chk_uv_drive: assert property ( // R17
      uv_s |=> !driver_en_r && !bus_drive_r)
      else $error("driver active in undervoltage");
   chk_slope_cs: assert property ( // R19
      !(cs_s && !cs_prev_r) |=> $stable(low_slope_r))
      else $error("slope changed without select edge");
endmodule // lmw_ctrl

// ---- lmw_ctrl_test.sv ----
// Self-checking testbench for the LIN mode and wake controller
`timescale 1ns/100ps
module lmw_ctrl_test;
   import lmw_pkg::*;
   localparam int TO     = 50;
   localparam int B_MODE = 8;
   localparam int B_SLP  = 6;
   localparam int B_STOP = 2;
   localparam int B_WCLR = 1;
   localparam int B_FCLR = 0;
   logic         sys_clk   = 1'b0;
   logic         rst_n;
   logic         ext_rec;
   logic         supply_uv;
   logic         stall;
   lmw_sbc_type  sbc;
   lmw_cfg_type  cfg;
   lmw_stat_type stat;
   lmw_req_type  req;
   lmw_evt_type  evt_data;
   logic         txd, cs_n, rxd, drv, int_n, evt_valid, evt_ready, bus_rx;
   int           errors = 0;
   int           check_count = 0;
   int           cycles = 0;
   int           rst_cnt = 0;
   int           ramp_cnt = 0;
   int           wd_cnt = 0;
   int           n0, n1, n2;
   always #2 sys_clk = ~sys_clk;
   // Bus with pull-up, pulled low by our driver or another node
   assign bus_rx = ~drv & ext_rec;
   lmw_ctrl #(.WAKE_CYC(20), .TO_CYC(TO)) dut
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .lin_transmit_input(txd),
      .bus_rx_level(bus_rx), .supply_uv(supply_uv), .spi_select_low(cs_n),
      .lin_receive_output(rxd), .bus_drive_dominant(drv), .sbc_mode(sbc),
      .cfg(cfg), .stat(stat), .req(req), .int_n(int_n),
      .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data)
   );
   lmw_mcu_model mcu
   (
      .sys_clk(sys_clk), .int_n(int_n), .evt_valid(evt_valid),
      .evt_data(evt_data), .stall(stall), .lin_transmit_input(txd),
      .spi_select_low(cs_n), .evt_ready(evt_ready)
   );
   // Request pulse counters and run limit
   always @(posedge sys_clk)
   begin
      cycles++;
      if (req.restart_req === 1'b1)
         rst_cnt <= rst_cnt + 1;
      if (req.supply_ramp_req === 1'b1)
         ramp_cnt <= ramp_cnt + 1;
      if (req.wd_enable_req === 1'b1)
         wd_cnt <= wd_cnt + 1;
      if (cycles == 20000)
      begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [63:0] s, e);
      check_count++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic pulse(input int b);
      @(posedge sys_clk);
      cfg.mode_wr   <= (b == B_MODE);
      cfg.slope_wr  <= (b == B_SLP);
      cfg.stop_cmd  <= (b == B_STOP);
      cfg.wake_clr  <= (b == B_WCLR);
      cfg.fault_clr <= (b == B_FCLR);
      @(posedge sys_clk);
      {cfg.mode_wr, cfg.slope_wr, cfg.stop_cmd} <= 3'h0;
      {cfg.wake_clr, cfg.fault_clr}             <= 2'h0;
      cyc(2);
   endtask
   task automatic wr(input logic [1:0] m);
      cfg.mode_req <= m;
      pulse(B_MODE);
   endtask
   task automatic bus_dom(input int n);
      @(posedge sys_clk);
      ext_rec <= 1'b0;
      cyc(n);
      ext_rec <= 1'b1;
      cyc(10);
   endtask
   task automatic t_reset();
      check("mode", stat.transceiver_a_mode_field, MODE_OFF_DEF);
      check("slope", stat.low_slope_active, 0);
      check("rxd", rxd, 1);
   endtask
   task automatic t_refuse();
      sbc <= SBC_STOP;
      wr(MODE_NRM_DEF);
      check("nrm stop", stat.transceiver_a_mode_field, MODE_OFF_DEF);
      wr(MODE_RX_DEF);
      check("rx stop", stat.transceiver_a_mode_field, MODE_RX_DEF);
      wr(MODE_OFF_DEF);
      sbc <= SBC_SLEEP;
      wr(MODE_RX_DEF);
      check("rx sleep", stat.transceiver_a_mode_field, MODE_OFF_DEF);
      n0 = rst_cnt;
      bus_dom(30);
      check("off wake", {rxd, rst_cnt - n0}, {1'b1, 32'h0});
      wr(MODE_WAKE);
      check("wk sleep", stat.transceiver_a_mode_field, MODE_WAKE);
   endtask
   task automatic t_sleep_wake();
      n0 = rst_cnt;
      n1 = ramp_cnt;
      n2 = mcu.int_cnt;
      bus_dom(30);
      check("slp req", {rst_cnt - n0, ramp_cnt - n1}, {32'h1, 32'h1});
      check("slp int", mcu.int_cnt - n2, 0);
      check("slp rxd", rxd, 0);
      check("slp mode", stat.transceiver_a_mode_field, MODE_WAKE);
      check("slp stat", stat.wake_source_status_reg, 1);
      sbc <= SBC_FAILSAFE;
      cyc(4);
      check("fs rearm", rxd, 1);
      wr(MODE_OFF_DEF);
      check("fs mode", stat.transceiver_a_mode_field, MODE_WAKE);
      n1 = ramp_cnt;
      bus_dom(30);
      check("fs ramp", ramp_cnt - n1, 1);
      sbc <= SBC_RESTART;
      wr(MODE_OFF_DEF);
      wr(MODE_WAKE);
      check("rs rearm", rxd, 1);
      n2 = mcu.int_cnt;
      bus_dom(30);
      check("rs wake", {rxd, mcu.int_cnt - n2}, {1'b0, 32'h0});
   endtask
   task automatic t_normal_wake();
      sbc <= SBC_NORMAL;
      wr(MODE_OFF_DEF);
      wr(MODE_WAKE);
      pulse(B_WCLR);
      n0 = mcu.int_cnt;
      n1 = mcu.evt_cnt;
      n2 = rst_cnt;
      bus_dom(10);
      check("short", {rxd, mcu.int_cnt - n0}, {1'b1, 32'h0});
      bus_dom(30);
      check("nrm int", mcu.int_cnt - n0, 1);
      check("nrm rxd", rxd, 0);
      check("nrm stat", stat.wake_source_status_reg, 1);
      check("nrm evt", mcu.evt_cnt - n1, 1);
      check("nrm sbc", rst_cnt - n2, 0);
      pulse(B_WCLR);
      check("stat clr", stat.wake_source_status_reg, 0);
      wr(MODE_OFF_DEF);
      check("rxd rel", rxd, 1);
   endtask
   task automatic t_stop_wake();
      wr(MODE_WAKE);
      sbc <= SBC_STOP;
      cfg.wd_disabled <= 1'b1;
      cfg.watchdog_on_bus_wake_enable <= 1'b1;
      n0 = wd_cnt;
      n1 = mcu.int_cnt;
      bus_dom(30);
      check("wd req", wd_cnt - n0, 1);
      check("stop int", mcu.int_cnt - n1, 1);
      pulse(B_STOP);
      check("stop rearm", rxd, 1);
      bus_dom(30);
      check("stop again", {rxd, mcu.int_cnt - n1}, {1'b0, 32'h2});
      cfg.wd_disabled <= 1'b0;
      cfg.watchdog_on_bus_wake_enable <= 1'b0;
      sbc <= SBC_NORMAL;
      wr(MODE_OFF_DEF);
   endtask
   task automatic t_enable();
      mcu.set_tx(1'b0);
      wr(MODE_NRM_DEF);
      cyc(EN_CYC + 10);
      check("early dom", drv, 0);
      mcu.set_tx(1'b1);
      cyc(4);
      mcu.set_tx(1'b0);
      cyc(8);
      check("dom sent", {drv, rxd, stat.driver_enable}, 3'h5);
   endtask
   task automatic t_timeout();
      cyc(TO + 20);
      check("to drv", drv, 0);
      check("to flag", {stat.transceiver_a_fault_flag, stat.txd_timeout_stat}, 2'b11);
      mcu.set_tx(1'b1);
      cyc(4);
      mcu.set_tx(1'b0);
      cyc(6);
      check("to rel", drv, 1);
      mcu.set_tx(1'b1);
      pulse(B_FCLR);
      cfg.transmit_timeout_disable <= 1'b1;
      mcu.set_tx(1'b0);
      cyc(TO + 20);
      check("to off", {drv, stat.txd_timeout_stat,
            stat.transceiver_a_fault_flag}, 3'h5);
      mcu.set_tx(1'b1);
      cfg.transmit_timeout_disable <= 1'b0;
   endtask
   task automatic t_uv_clamp();
      supply_uv <= 1'b1;
      mcu.set_tx(1'b0);
      cyc(6);
      check("uv drv", {drv, stat.driver_enable}, 2'h0);
      ext_rec <= 1'b0;
      cyc(6);
      check("uv rx", rxd, 0);
      ext_rec <= 1'b1;
      supply_uv <= 1'b0;
      cyc(8);
      check("uv end", drv, 1);
      mcu.set_tx(1'b1);
      wr(MODE_RX_DEF);
      mcu.set_tx(1'b0);
      ext_rec <= 1'b0;
      cyc(TO + 20);
      check("rx drv", drv, 0);
      check("clamp", {stat.transceiver_a_fault_flag, stat.bus_clamp_stat}, 2'b11);
      check("cl mode", stat.transceiver_a_mode_field, MODE_RX_DEF);
      ext_rec <= 1'b1;
      mcu.set_tx(1'b1);
      pulse(B_FCLR);
   endtask
   task automatic t_slope();
      cfg.low_slope_select <= 1'b1;
      pulse(B_SLP);
      check("slope wait", stat.low_slope_active, 0);
      mcu.select_pulse();
      check("slope low", stat.low_slope_active, 1);
      sbc <= SBC_STOP;
      cfg.low_slope_select <= 1'b0;
      pulse(B_SLP);
      mcu.select_pulse();
      check("slope stop", stat.low_slope_active, 1);
      sbc <= SBC_NORMAL;
   endtask
   task automatic t_fifo();
      stall <= 1'b1;
      n0 = mcu.evt_cnt;
      repeat (17)
      begin
         wr(MODE_OFF_DEF);
         wr(MODE_WAKE);
         bus_dom(30);
      end
      check("full", {evt_valid, rxd}, 2'b10);
      check("evt word", evt_data, {SBC_NORMAL, 3'h1});
      stall <= 1'b0;
      cyc(40);
      check("drained", {evt_valid, mcu.evt_cnt - n0}, {1'b0, 32'h11});
   endtask
   initial
   begin
      rst_n     <= 1'b0;
      ext_rec   <= 1'b1;
      supply_uv <= 1'b0;
      stall     <= 1'b0;
      sbc       <= SBC_NORMAL;
      cfg       <= '0;
      cyc(6);
      rst_n <= 1'b1;
      t_reset();
      t_refuse();
      t_sleep_wake();
      t_normal_wake();
      t_stop_wake();
      t_enable();
      t_timeout();
      t_uv_clamp();
      t_slope();
      t_fifo();
      end_of_test();
   end
endmodule // lmw_ctrl_test

// ---- lmw_fifo.sv ----
// Event FIFO with valid and ready on both sides
`timescale 1ns/100ps
module lmw_fifo
#(
   parameter int W     = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
)
(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;
   logic         full;
   logic         empty;

   assign empty     = (wp_r == rp_r);
   assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_r[AW-1:0]];

   always_ff @(posedge sys_clk)
   begin
      if (in_valid && !full)
         mem[wp_r[AW-1:0]] <= in_data;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         if (in_valid && !full)
            wp_r <= wp_r + 1'b1;
         if (out_ready && !empty)
            rp_r <= rp_r + 1'b1;
      end
   end
endmodule // lmw_fifo

// ---- lmw_mcu_model.sv ----
// Microcontroller model: transmit pin, chip select and event sink
`timescale 1ns/100ps
module lmw_mcu_model
(
   // Clock
   input  wire logic                 sys_clk,
   // From device, plus stall from the testbench
   input  wire logic                 int_n,
   input  wire logic                 evt_valid,
   input  wire lmw_pkg::lmw_evt_type evt_data,
   input  wire logic                 stall,
   // To device
   output logic                      lin_transmit_input,
   output logic                      spi_select_low,
   output logic                      evt_ready
);
   import lmw_pkg::*;
   int int_cnt = 0;
   int evt_cnt = 0;
   initial
   begin
      lin_transmit_input = 1'b1;
      spi_select_low     = 1'b1;
   end
   // Sink holds off while stalled
   assign evt_ready = ~stall;
   // Interrupt pulses and drained words
   always @(posedge sys_clk)
   begin
      if (int_n === 1'b0)
         int_cnt <= int_cnt + 1;
      if (evt_valid === 1'b1 && evt_ready === 1'b1)
         evt_cnt <= evt_cnt + 1;
   end
   // Transmit level; caller returns recessive before the next dominant
   task automatic set_tx(input logic v);
      @(posedge sys_clk);
      lin_transmit_input <= v;
   endtask
   // Select low then high ends an SPI write
   task automatic select_pulse();
      @(posedge sys_clk);
      spi_select_low <= 1'b0;
      repeat (3) @(posedge sys_clk);
      spi_select_low <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule // lmw_mcu_model

// ---- lmw_pkg.sv ----
// Constants and types for the LIN transceiver mode and wake controller
// Operation
// R1: After entering normal mode, wait the enabling time before passing any dominant.
// R2: Dominant held across enabling must return recessive; next dominant bit is sent.
// R3: Receive-only disables the driver, keeps reception; chip Normal or Stop only.
// R4: Wake-capable selectable in Stop, Sleep, Restart, Normal; forced in Fail-Safe.
// R5: Wake is a dominant longer than the filter, taking effect at the release.
// R6: A wake pulls the receive output low until the mode is changed.
// R7: Wake action by chip mode: interrupt low, or restart with supply ramp.
// R8: After a wake the mode field keeps reading the wake-capable code.
// R9: Writing another mode then wake-capable again rearms wake monitoring.
// R10: Entering Stop, Sleep, Fail-Safe, or Stop commanded again, rearms wake.
// R11: Wake in Stop or Normal is reported; no automatic move to Normal.
// R12: Wake in Stop enables a disabled watchdog when the wake-watchdog bit is set.
// R13: Wake from Sleep requests Restart, pulls receive low, gives no interrupt.
// R14: Transmit input dominant past timeout blocks driver, flags fault until release.
// R15: One control bit disables the transmit-dominant timeout.
// R16: Bus dominant past timeout in normal or receive-only sets fault, mode unchanged.
// R17: Supply undervoltage forces receive-only behaviour until the supply recovers.
// R18: Low slope for 10.4 kBaud, normal slope for 20 kBaud; normal after reset.
// R19: Slope written in chip Normal only, applied at select rising edge.
// R20: Off is the reset mode, allowed in every chip mode, ignores wakes; the code refuses an Off write in Fail-Safe.
// R21: Normal transceiver mode is selectable only in chip Normal mode.
// R22: The wake dominant filter time lies between 30 and 150 us.
// R23: Two-bit mode field; non-wake codes are parameters.
// R24: Enabling, wake filter and timeout are parameterised cycle counts; the enabling count EN_CYC is a package constant, not a module parameter.
package lmw_pkg;
   localparam int         CLK_MHZ      = 250;
   localparam int         EN_TIME_US   = 10;
   localparam int         WAKE_FILT_US = 30;
   localparam int         TO_TIME_US   = 10000;
   localparam int         EN_CYC       = EN_TIME_US * CLK_MHZ;
   localparam int         WAKE_CYC_DEF = WAKE_FILT_US * CLK_MHZ;
   localparam int         TO_CYC_DEF   = TO_TIME_US * CLK_MHZ;
   localparam int         CNT_W        = 22;
   localparam int         FIFO_DEPTH   = 16;
   localparam logic [1:0] MODE_WAKE    = 2'h1;
   localparam logic [1:0] MODE_OFF_DEF = 2'h0;
   localparam logic [1:0] MODE_RX_DEF  = 2'h2;
   localparam logic [1:0] MODE_NRM_DEF = 2'h3;
   localparam logic [3:0] SYNC_RST     = 4'hB;

   typedef enum logic [4:0]
   {
      SBC_NORMAL   = 5'h01,
      SBC_STOP     = 5'h02,
      SBC_SLEEP    = 5'h04,
      SBC_RESTART  = 5'h08,
      SBC_FAILSAFE = 5'h10
   } lmw_sbc_type;

   typedef enum logic [7:0]
   {
      ST_OFF     = 8'h01,
      ST_EN_WAIT = 8'h02,
      ST_NORMAL  = 8'h04,
      ST_RXONLY  = 8'h08,
      ST_WK_IDLE = 8'h10,
      ST_WK_DOM  = 8'h20,
      ST_WK_QUAL = 8'h40,
      ST_WOKEN   = 8'h80
   } lmw_st_type;

   typedef struct packed
   {
      logic [1:0] mode_req;
      logic       mode_wr;
      logic       low_slope_select;
      logic       slope_wr;
      logic       transmit_timeout_disable;
      logic       watchdog_on_bus_wake_enable;
      logic       wd_disabled;
      logic       stop_cmd;
      logic       wake_clr;
      logic       fault_clr;
   } lmw_cfg_type;

   typedef struct packed
   {
      logic [1:0] transceiver_a_mode_field;
      logic       transceiver_a_fault_flag;
      logic       txd_timeout_stat;
      logic       bus_clamp_stat;
      logic       wake_source_status_reg;
      logic       low_slope_active;
      logic       driver_enable;
   } lmw_stat_type;

   typedef struct packed
   {
      logic restart_req;
      logic supply_ramp_req;
      logic wd_enable_req;
   } lmw_req_type;

   typedef struct packed
   {
      logic [4:0] sbc;
      logic       clamp;
      logic       txd_to;
      logic       wake;
   } lmw_evt_type;
endpackage
